// ==== verilog/intc_map.vh ====
`ifndef INTC_MAP_VH
`define INTC_MAP_VH
// =====================================================================
// Register addresses of the interrupt controller.
// =====================================================================
`define SECOND_ENABLE_ADDR 8'ha7
`define MAIN_ENABLE_ADDR 8'ha8
`define SECOND_LEVEL_ADDR 8'hb7
`define MAIN_LEVEL_ADDR 8'hb8
// Reset value of all four registers.
`define INTC_REG_RESET 8'h00
// =====================================================================
// Bit positions inside the main registers.
// =====================================================================
`define GLOBAL_ENABLE_BIT 7
`define TIMER2_BIT 5
`define SERIAL1_BIT 4
`define TIMER1_BIT 3
`define PIN1_BIT 2
`define TIMER0_BIT 1
`define PIN0_BIT 0
// Bit positions inside the second registers.
`define DISPLAY_CHAN_BIT 7
`define SERIAL2_BIT 4
`define TWOWIRE_BIT 1
`define USB_BIT 0
// Writable masks; reserved and unused bits read as zero.
`define MAIN_ENABLE_MASK 8'hbf
`define MAIN_LEVEL_MASK 8'h3f
`define SECOND_MASK 8'h93
// =====================================================================
// Source indices in polling order, first is served first within a level.
// =====================================================================
`define SRC_PIN0 4'h0
`define SRC_SERIAL2 4'h1
`define SRC_TIMER0 4'h2
`define SRC_TWOWIRE 4'h3
`define SRC_PIN1 4'h4
`define SRC_DISPLAY_CHAN 4'h5
`define SRC_TIMER1 4'h6
`define SRC_USB 4'h7
`define SRC_SERIAL1 4'h8
`define SRC_TIMER2 4'h9
// Vector addresses per source.
`define VEC_PIN0 16'h0003
`define VEC_TIMER0 16'h000b
`define VEC_PIN1 16'h0013
`define VEC_TIMER1 16'h001b
`define VEC_SERIAL1 16'h0023
`define VEC_TIMER2 16'h002b
`define VEC_USB 16'h0033
`define VEC_DISPLAY_CHAN 16'h003b
`define VEC_TWOWIRE 16'h0043
`define VEC_SERIAL2 16'h004b
`endif

// ==== verilog/intc_poll_pick.v ====
`timescale 1ns/1ps
// =====================================================================
// Fixed-order picker: lowest set index wins.
// =====================================================================
module intc_poll_pick #(
    parameter N = 10
) (
    input wire [N-1:0] req_i, // Candidate requests, bit 0 polled first.
    output reg found_o, // High when any candidate is set.
    output reg [3:0] index_o // Index of the winning candidate.
);
    integer k;

    // Scan from the last index down so the first index overwrites last.
    always @* begin
        found_o = 1'b0;
        index_o = 4'h0;
        for (k = N - 1; k >= 0; k = k - 1) begin
            if (req_i[k]) begin
                found_o = 1'b1;
                index_o = k[3:0];
            end
        end
    end
endmodule // intc_poll_pick

// ==== verilog/vectored_interrupt_ctrl.v ====
`timescale 1ns/1ps
`include "intc_map.vh"
module vectored_interrupt_ctrl #(
    parameter NUM_SRC = 10
) (
    input wire clock_i, // Core clock.
    input wire nrst_i, // Asynchronous reset, active low.
    // Register access from the core's special register bus.
    input wire [7:0] reg_addr_i, // Register address.
    input wire [7:0] reg_wdata_i, // Write data.
    input wire reg_wr_i, // Write strobe, one cycle.
    input wire reg_rd_i, // Read strobe, marks an access too.
    output reg [7:0] reg_rdata_o, // Read data, registered.
    // Core sequencing.
    input wire flag_sample_phase_i, // Pulse at the sampling state of each machine cycle.
    input wire poll_phase_i, // Pulse marking the polling point of each machine cycle.
    input wire last_cycle_i, // High in the final machine cycle of an instruction.
    input wire return_from_interrupt_i, // Pulse when a return-from-interrupt executes.
    input wire plain_return_i, // Pulse when a plain subroutine return executes.
    input wire call_done_i, // Pulse when the core has pushed the counter and jumped.
    // Request flags in polling order index (same clock domain).
    input wire [NUM_SRC-1:0] flags_i, // Raw request flags.
    input wire pin0_edge_mode_i, // Pin 0 flag is transition triggered.
    input wire pin1_edge_mode_i, // Pin 1 flag is transition triggered.
    // Outputs to the core.
    output reg hardware_long_call_o, // Request to perform the hardware call, held until done.
    output reg [15:0] vector_o, // Target address of the call.
    output reg push_pc_o, // Push the counter on the stack during the call.
    output wire save_status_o, // Always low: status word is not saved.
    output reg pop_pc_o, // Pop two bytes into the counter on return.
    output reg [NUM_SRC-1:0] flag_clear_o, // One-cycle clears to peripheral flags.
    output wire [1:0] in_progress_o // Level in-progress bits, bit 1 high level.
);
    // =================================================================
    // Registers.
    // =================================================================
    reg [7:0] main_enable_reg; // Main enable register.
    reg [7:0] second_enable_reg; // Second enable register.
    reg [7:0] main_level_reg; // Main level register.
    reg [7:0] second_level_reg; // Second level register.
    reg [NUM_SRC-1:0] sample_reg; // Flags captured at the sampling phase.
    reg high_busy_reg; // High level routine in progress.
    reg low_busy_reg; // Low level routine in progress.
    reg blocked_reg; // Current instruction is a return-from-interrupt or register access.
    reg [3:0] call_src_reg; // Source being vectored.
    reg call_high_reg; // Level of the source being vectored.

    wire [NUM_SRC-1:0] enable_vec; // Enables in polling order.
    wire [NUM_SRC-1:0] level_vec; // Level bits in polling order.
    wire [NUM_SRC-1:0] armed; // Sampled, enabled requests.
    wire [NUM_SRC-1:0] high_req; // Armed high level requests.
    wire high_found; // Some high request armed.
    wire low_found; // Some low request armed.
    wire [3:0] high_idx; // Winning high request.
    wire [3:0] low_idx; // Winning low request.
    wire reg_access; // Core touches one of the four registers.
    reg call_next; // Decision to start a call.
    reg call_hi_next; // Level of the started call.
    reg [3:0] call_src_next; // Source of the started call.
    reg [15:0] vec_next; // Vector of the started call.

    assign save_status_o = 1'b0;
    assign in_progress_o = {high_busy_reg, low_busy_reg};

    // Gather the scattered bits into polling order.
    assign enable_vec = {main_enable_reg[`TIMER2_BIT], main_enable_reg[`SERIAL1_BIT],
        second_enable_reg[`USB_BIT], main_enable_reg[`TIMER1_BIT], second_enable_reg[`DISPLAY_CHAN_BIT],
        main_enable_reg[`PIN1_BIT], second_enable_reg[`TWOWIRE_BIT], main_enable_reg[`TIMER0_BIT],
        second_enable_reg[`SERIAL2_BIT], main_enable_reg[`PIN0_BIT]};
    assign level_vec = {main_level_reg[`TIMER2_BIT], main_level_reg[`SERIAL1_BIT],
        second_level_reg[`USB_BIT], main_level_reg[`TIMER1_BIT], second_level_reg[`DISPLAY_CHAN_BIT],
        main_level_reg[`PIN1_BIT], second_level_reg[`TWOWIRE_BIT], main_level_reg[`TIMER0_BIT],
        second_level_reg[`SERIAL2_BIT], main_level_reg[`PIN0_BIT]};

    // The global bit gates every source before arbitration.
    assign armed = main_enable_reg[`GLOBAL_ENABLE_BIT] ? (sample_reg & enable_vec) : {NUM_SRC{1'b0}};
    assign high_req = armed & level_vec;

    // Low candidates are armed requests with the level bit clear, whether or not a high candidate exists.
    assign low_found = |(armed & ~level_vec);

    // =================================================================
    // Arbitration within each level by polling order.
    // =================================================================
    intc_poll_pick #(.N(NUM_SRC)) u_pick_high (
        .req_i(high_req),
        .found_o(high_found),
        .index_o(high_idx)
    );

    intc_poll_pick #(.N(NUM_SRC)) u_pick_low (
        .req_i(armed & ~level_vec),
        .found_o(),
        .index_o(low_idx)
    );

    assign reg_access = (reg_wr_i | reg_rd_i) &&
        (reg_addr_i == `MAIN_ENABLE_ADDR || reg_addr_i == `SECOND_ENABLE_ADDR ||
         reg_addr_i == `MAIN_LEVEL_ADDR || reg_addr_i == `SECOND_LEVEL_ADDR);

    // Vector lookup by source index.
    function [15:0] vec_of;
        input [3:0] s;
        begin
            case (s)
                `SRC_PIN0: vec_of = `VEC_PIN0;
                `SRC_SERIAL2: vec_of = `VEC_SERIAL2;
                `SRC_TIMER0: vec_of = `VEC_TIMER0;
                `SRC_TWOWIRE: vec_of = `VEC_TWOWIRE;
                `SRC_PIN1: vec_of = `VEC_PIN1;
                `SRC_DISPLAY_CHAN: vec_of = `VEC_DISPLAY_CHAN;
                `SRC_TIMER1: vec_of = `VEC_TIMER1;
                `SRC_USB: vec_of = `VEC_USB;
                `SRC_SERIAL1: vec_of = `VEC_SERIAL1;
                default: vec_of = `VEC_TIMER2;
            endcase
        end
    endfunction

    // =================================================================
    // Poll decision; looks only at the latest samples.
    // =================================================================
    always @* begin
        call_next = 1'b0;
        call_hi_next = 1'b0;
        call_src_next = 4'h0;
        if (poll_phase_i && last_cycle_i && !blocked_reg && !return_from_interrupt_i && !reg_access
            && !hardware_long_call_o) begin
            if (high_found && !high_busy_reg) begin
                call_next = 1'b1;
                call_hi_next = 1'b1;
                call_src_next = high_idx;
            end else if (low_found && !high_busy_reg && !low_busy_reg) begin
                call_next = 1'b1;
                call_src_next = low_idx;
            end else begin
                call_next = 1'b0;
            end
        end
        vec_next = vec_of(call_src_next);
    end

    // =================================================================
    // Flag sampling and instruction blocking memory.
    // =================================================================
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sample_reg <= {NUM_SRC{1'b0}};
            blocked_reg <= 1'b0;
        end else begin
            // Each sample replaces the last, nothing is remembered.
            if (flag_sample_phase_i) begin
                sample_reg <= flags_i;
            end
            // Remember a blocking instruction until its last cycle ends.
            if (return_from_interrupt_i || reg_access) begin
                blocked_reg <= 1'b1;
            end else if (poll_phase_i && last_cycle_i) begin
                blocked_reg <= 1'b0;
            end
        end
    end

    // =================================================================
    // Hardware call handshake and level tracking.
    // =================================================================
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hardware_long_call_o <= 1'b0;
            push_pc_o <= 1'b0;
            pop_pc_o <= 1'b0;
            vector_o <= 16'h0000;
            call_src_reg <= 4'h0;
            call_high_reg <= 1'b0;
            high_busy_reg <= 1'b0;
            low_busy_reg <= 1'b0;
            flag_clear_o <= {NUM_SRC{1'b0}};
        end else begin
            flag_clear_o <= {NUM_SRC{1'b0}};
            pop_pc_o <= return_from_interrupt_i;
            if (call_next) begin
                // Start the call: push counter, load vector.
                hardware_long_call_o <= 1'b1;
                push_pc_o <= 1'b1;
                vector_o <= vec_next;
                call_src_reg <= call_src_next;
                call_high_reg <= call_hi_next;
                // Mark the level as in progress.
                if (call_hi_next) begin
                    high_busy_reg <= 1'b1;
                end else begin
                    low_busy_reg <= 1'b1;
                end
                // Hardware clears edge pin and timer 0/1 flags; timer 2 left to software.
                if (call_src_next == `SRC_PIN0 && pin0_edge_mode_i) begin
                    flag_clear_o[`SRC_PIN0] <= 1'b1;
                end
                if (call_src_next == `SRC_PIN1 && pin1_edge_mode_i) begin
                    flag_clear_o[`SRC_PIN1] <= 1'b1;
                end
                if (call_src_next == `SRC_TIMER0 || call_src_next == `SRC_TIMER1) begin
                    flag_clear_o[call_src_next] <= 1'b1;
                end
            end else if (call_done_i) begin
                hardware_long_call_o <= 1'b0;
                push_pc_o <= 1'b0;
            end else if (return_from_interrupt_i) begin
                // Clear the high level first when both are set.
                if (high_busy_reg) begin
                    high_busy_reg <= 1'b0;
                end else begin
                    low_busy_reg <= 1'b0;
                end
            end else begin
                // A plain return leaves the level bits alone.
                high_busy_reg <= high_busy_reg;
            end
        end
    end

    // =================================================================
    // Register file writes.
    // =================================================================
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            main_enable_reg <= `INTC_REG_RESET;
            second_enable_reg <= `INTC_REG_RESET;
            main_level_reg <= `INTC_REG_RESET;
            second_level_reg <= `INTC_REG_RESET;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `MAIN_ENABLE_ADDR: main_enable_reg <= reg_wdata_i & `MAIN_ENABLE_MASK;
                `SECOND_ENABLE_ADDR: second_enable_reg <= reg_wdata_i & `SECOND_MASK;
                `MAIN_LEVEL_ADDR: main_level_reg <= reg_wdata_i & `MAIN_LEVEL_MASK;
                `SECOND_LEVEL_ADDR: second_level_reg <= reg_wdata_i & `SECOND_MASK;
                default: main_enable_reg <= main_enable_reg;
            endcase
        end
    end

    // =================================================================
    // Register reads, one cycle after the strobe.
    // =================================================================
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `MAIN_ENABLE_ADDR: reg_rdata_o <= main_enable_reg;
                `SECOND_ENABLE_ADDR: reg_rdata_o <= second_enable_reg;
                `MAIN_LEVEL_ADDR: reg_rdata_o <= main_level_reg;
                `SECOND_LEVEL_ADDR: reg_rdata_o <= second_level_reg;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end
endmodule // vectored_interrupt_ctrl

// ==== verif/intc_checker_assertions.sv ====
`timescale 1ns/1ps
// =====================================================================
// Port checks of the vectored interrupt controller.
// =====================================================================
module intc_checker #(
    parameter NUM_SRC = 10
) (
    input wire clock_i,
    input wire nrst_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire poll_phase_i,
    input wire last_cycle_i,
    input wire return_from_interrupt_i,
    input wire call_done_i,
    input wire hardware_long_call_o,
    input wire [15:0] vector_o,
    input wire push_pc_o,
    input wire save_status_o,
    input wire pop_pc_o,
    input wire [NUM_SRC-1:0] flag_clear_o,
    input wire [1:0] in_progress_o
);
    // Shadow of the global enable bit, taken from register writes.
    reg ge_reg;
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) ge_reg <= 1'b0;
        else if (reg_wr_i && reg_addr_i == 8'ha8) ge_reg <= reg_wdata_i[7];
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    // A call start always marks a level as busy.
    sequence launch_s; $rose(hardware_long_call_o) && (in_progress_o != 2'b00); endsequence
    // The counter is popped in the cycle after a return.
    sequence popped_s; ##1 pop_pc_o; endsequence
    save_never_a: assert property (save_status_o == 1'b0) else $error("status word saved");
    push_tracks_a: assert property (push_pc_o == hardware_long_call_o) else $error("push not with call");
    call_polled_a: assert property ($rose(hardware_long_call_o) |-> $past(poll_phase_i && last_cycle_i))
        else $error("call without last-cycle poll");
    global_gate_a: assert property ($rose(hardware_long_call_o) |-> $past(ge_reg))
        else $error("call with global enable clear");
    high_blocks_a: assert property ($rose(hardware_long_call_o) |-> !$past(in_progress_o[1]))
        else $error("call during high routine");
    vector_hold_a: assert property (hardware_long_call_o && $past(hardware_long_call_o) |-> $stable(vector_o))
        else $error("vector moved during call");
    call_ends_a: assert property (call_done_i |=> !hardware_long_call_o) else $error("call held after done");
    clear_with_call_a: assert property (|flag_clear_o |-> $rose(hardware_long_call_o))
        else $error("flag clear outside call start");
    level_marked_a: assert property ($rose(hardware_long_call_o) |-> launch_s) else $error("no level busy");
    return_pops_a: assert property (return_from_interrupt_i |-> popped_s) else $error("no pop on return");
endmodule // intc_checker
bind vectored_interrupt_ctrl intc_checker #(.NUM_SRC(NUM_SRC)) chk_i (.clock_i(clock_i), .nrst_i(nrst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .poll_phase_i(poll_phase_i),
    .last_cycle_i(last_cycle_i), .return_from_interrupt_i(return_from_interrupt_i), .call_done_i(call_done_i),
    .hardware_long_call_o(hardware_long_call_o), .vector_o(vector_o), .push_pc_o(push_pc_o),
    .save_status_o(save_status_o), .pop_pc_o(pop_pc_o), .flag_clear_o(flag_clear_o),
    .in_progress_o(in_progress_o));

// ==== verif/core_seq_model.sv ====
`timescale 1ns/1ps
// =====================================================================
// Core sequencer model: performs the call and reports completion.
// =====================================================================
module core_seq_model (
    input wire clock_i,
    input wire nrst_i,
    input wire call_i, // Call request from the controller.
    input wire slow_i, // Take five cycles instead of two.
    output reg done_o // One-cycle completion pulse.
);
    reg [2:0] cnt_reg; // Cycles spent on the current call.
    // Push the counter, load the vector, then pulse done once.
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_reg <= 3'h0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (call_i && !done_o && cnt_reg == (slow_i ? 3'h4 : 3'h1)) begin
                done_o <= 1'b1;
                cnt_reg <= 3'h0;
            end else if (call_i && !done_o) begin
                cnt_reg <= cnt_reg + 3'h1;
            end
        end
    end
endmodule // core_seq_model

// ==== verif/tb_vectored_interrupt_ctrl.sv ====
`timescale 1ns/1ps
module tb_vectored_interrupt_ctrl;
    reg clock_i, nrst_i, reg_wr_i, reg_rd_i, samp, poll, last, rfi, pret, e0, e1, slow;
    reg [7:0] addr, wdata, me, se, ml, sl;
    reg [9:0] flags;
    reg [31:0] lfsr;
    wire call, push, save, pop, done;
    wire [7:0] rdata;
    wire [15:0] vec;
    wire [9:0] clr;
    wire [1:0] ip;
    integer bad_count, n_tests, i;
    // =================================================================
    // Design, core model and clock.
    // =================================================================
    vectored_interrupt_ctrl DUT (.clock_i(clock_i), .nrst_i(nrst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata), .flag_sample_phase_i(samp),
        .poll_phase_i(poll), .last_cycle_i(last), .return_from_interrupt_i(rfi), .plain_return_i(pret),
        .call_done_i(done), .flags_i(flags), .pin0_edge_mode_i(e0), .pin1_edge_mode_i(e1),
        .hardware_long_call_o(call), .vector_o(vec), .push_pc_o(push), .save_status_o(save),
        .pop_pc_o(pop), .flag_clear_o(clr), .in_progress_o(ip));
    core_seq_model core_i (.clock_i(clock_i), .nrst_i(nrst_i), .call_i(call), .slow_i(slow), .done_o(done));
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    // =================================================================
    // Expectation helpers.
    // =================================================================
    function [31:0] next_rnd(input [31:0] s);
        next_rnd = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Register bits gathered into polling order.
    function [9:0] spread(input [7:0] m, input [7:0] s);
        spread = {m[5], m[4], s[0], m[3], s[7], m[2], s[1], m[1], s[4], m[0]};
    endfunction
    function [15:0] vec_of(input [3:0] k);
        case (k)
            4'h0: vec_of = 16'h0003;
            4'h1: vec_of = 16'h004b;
            4'h2: vec_of = 16'h000b;
            4'h3: vec_of = 16'h0043;
            4'h4: vec_of = 16'h0013;
            4'h5: vec_of = 16'h003b;
            4'h6: vec_of = 16'h001b;
            4'h7: vec_of = 16'h0033;
            4'h8: vec_of = 16'h0023;
            default: vec_of = 16'h002b;
        endcase
    endfunction
    // Winner as {found, high, index}; high first, then lowest index.
    function [5:0] pick(input [9:0] f, input [1:0] busy);
        reg [9:0] en, hi;
        integer k;
        begin
            en = spread(me, se) & f & {10{me[7]}};
            hi = en & spread(ml, sl);
            pick = 6'h00;
            for (k = 9; k >= 0; k = k - 1) if (!busy[1] && hi[k]) pick = {2'b11, k[3:0]};
            if (!pick[5]) for (k = 9; k >= 0; k = k - 1) if (busy == 2'b00 && en[k]) pick = {2'b10, k[3:0]};
        end
    endfunction
    // =================================================================
    // Drivers and checks.
    // =================================================================
    task complete_run;
        begin
            if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    task chk(input logic ok, input string msg);
        begin
            n_tests = n_tests + 1;
            if (ok !== 1'b1) begin
                bad_count = bad_count + 1;
                $display("CHECK FAILED at %0t ns: %s", $time, msg);
            end
        end
    endtask
    task step;
        @(posedge clock_i) #1;
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin addr = a; wdata = d; reg_wr_i = 1'b1; step; reg_wr_i = 1'b0; step; end
    endtask
    task rd(input [7:0] a, input [7:0] e);
        begin addr = a; reg_rd_i = 1'b1; step; reg_rd_i = 1'b0; chk(rdata === e, "register read"); step; end
    endtask
    // One machine cycle: sample the flags, then poll them.
    task mcyc(input [9:0] f, input lc);
        begin flags = f; samp = 1'b1; step; samp = 1'b0; poll = 1'b1; last = lc; step; poll = 1'b0; last = 1'b0; end
    endtask
    // Poll once and compare the call against the expected winner.
    task go(input [9:0] f, input lc, input blk);
        reg [5:0] p;
        reg [9:0] ec;
        begin
            p = (blk || !lc) ? 6'h00 : pick(f, ip);
            ec = 10'h000;
            if (p[5]) ec[p[3:0]] = (p[3:0] == 2 || p[3:0] == 6 || (p[3:0] == 0 && e0) || (p[3:0] == 4 && e1));
            mcyc(f, lc);
            chk(call === p[5], "call request");
            chk((clr & 10'h255) === ec, "flag clears");
            if (p[5]) chk(vec === vec_of(p[3:0]) && ip[p[4]] === 1'b1, "vector or level");
        end
    endtask
    // Wait for the core to finish the call, bounded.
    task fin;
        for (i = 0; i < 20 && call !== 1'b0; i = i + 1) step;
        if (call !== 1'b0) begin chk(1'b0, "call never ended"); complete_run; end
    endtask
    // Return from interrupt, then a quiet cycle that ends its instruction.
    task ret;
        begin rfi = 1'b1; step; rfi = 1'b0; mcyc(10'h000, 1'b1); end
    endtask
    // =================================================================
    // Main sequence.
    // =================================================================
    initial begin
        {reg_wr_i, reg_rd_i, samp, poll, last, rfi, pret, e0, e1, slow} = 10'h000;
        {addr, wdata, me, se, ml, sl} = 48'h0;
        flags = 10'h000; lfsr = 32'h57a7; bad_count = 0; n_tests = 0;
        nrst_i = 1'b0;
        repeat (2) @(posedge clock_i);
        #1 nrst_i = 1'b1;
        rd(8'ha7, 8'h00); rd(8'ha8, 8'h00); rd(8'hb7, 8'h00); rd(8'hb8, 8'h00);
        rd(8'ha9, 8'h00);
        // Random configurations, flags and edge modes.
        repeat (60) begin
            lfsr = next_rnd(lfsr);
            wr(8'ha8, lfsr[7:0]); wr(8'ha7, lfsr[15:8]); wr(8'hb8, lfsr[23:16]); wr(8'hb7, lfsr[31:24]);
            me = lfsr[7:0] & 8'hbf; se = lfsr[15:8] & 8'h93; ml = lfsr[23:16] & 8'h3f; sl = lfsr[31:24] & 8'h93;
            rd(8'ha8, me); rd(8'hb7, sl);
            lfsr = next_rnd(lfsr);
            {e0, e1, slow} = lfsr[12:10];
            mcyc(10'h000, 1'b1);
            go(lfsr[9:0], 1'b1, 1'b0);
            if (call === 1'b1) begin fin; ret; end
        end
        // Low routine nested by a high one, which blocks everything.
        me = 8'h83; se = 8'h00; ml = 8'h01; sl = 8'h00;
        wr(8'ha8, me); wr(8'ha7, se); wr(8'hb8, ml); wr(8'hb7, sl); mcyc(10'h000, 1'b1);
        go(10'h004, 1'b1, 1'b0); fin;
        go(10'h001, 1'b1, 1'b0); fin;
        go(10'h005, 1'b1, 1'b0);
        pret = 1'b1; step; pret = 1'b0; go(10'h004, 1'b1, 1'b0); chk(ip === 2'b11, "plain return");
        rfi = 1'b1; step; rfi = 1'b0; step; chk(ip === 2'b01, "high cleared first");
        mcyc(10'h000, 1'b1); ret; chk(ip === 2'b00, "low cleared");
        go(10'h004, 1'b0, 1'b0);
        rd(8'ha8, me); go(10'h004, 1'b1, 1'b1);
        go(10'h000, 1'b1, 1'b0);
        go(10'h004, 1'b1, 1'b0); fin; ret;
        complete_run;
    end
endmodule // tb_vectored_interrupt_ctrl
